// ### logic/cell_port_pkg.sv
/*
  shared constants and the mode type for the cell inlet/outlet port pair.
  assumes both ends are clocked at 50 MHz and share one link.
*/
package cell_port_pkg;
  localparam int          CLK_MHZ         = 50;
  localparam int          CELL_BYTES      = 53;
  localparam logic [5:0]  LAST_BYTE_IDX   = 6'h34;
  localparam logic [5:0]  GFC_BYTE_IDX    = 6'h00;
  localparam int          GFC_MSB         = 7;
  localparam int          GFC_LSB         = 4;
  localparam logic [5:0]  PTI_BYTE_IDX    = 6'h03;
  localparam int          PTI_CI_BIT      = 1;
  localparam logic [1:0]  LINE_CLK_SELECT = 2'h2;
  localparam logic [2:0]  CLK_DIV_HALF    = 3'h3;
  localparam int          FIFO_DEPTH      = 8;
  localparam int          FIFO_WIDTH      = 9;
  localparam logic [7:0]  ACK_NONE        = 8'h00;

  typedef enum logic [1:0] {
    MODE_UTOPIA,
    MODE_SIXTEEN,
    MODE_BACK_TO_BACK,
    MODE_LINE_IF
  } port_mode_type;
endpackage

// ### logic/cell_port_if.sv
/*
  carrier for the cell port link between the device end and the far end.
  assumes the bench resolves nothing: every pin here has one driver per role.
*/
`timescale 1ns/1ns
interface cell_port_if;
  logic       inlet_ack_flag;
  logic       inlet_reject_flag;
  logic       inlet_second_flag;
  logic       inlet_fourth_flag;
  logic       inlet_cell_start;
  logic [7:0] inlet_byte_bus;
  logic       inlet_enable_n;
  logic       outlet_cell_available;
  logic       outlet_transfer_clock;
  logic       outlet_enable_n;
  logic [7:0] outlet_byte_bus;
  logic       outlet_cell_start;
  logic       lim_transmit_load;

  modport device (
    output inlet_ack_flag, inlet_reject_flag,
    input  inlet_second_flag, inlet_fourth_flag, inlet_cell_start, inlet_byte_bus,
    input  inlet_enable_n,
    input  outlet_cell_available, outlet_transfer_clock, outlet_enable_n,
    output outlet_byte_bus, outlet_cell_start,
    input  lim_transmit_load
  );
  modport far_end (
    input  inlet_ack_flag, inlet_reject_flag,
    output inlet_second_flag, inlet_fourth_flag, inlet_cell_start, inlet_byte_bus,
    output inlet_enable_n,
    output outlet_cell_available, outlet_transfer_clock, outlet_enable_n,
    input  outlet_byte_bus, outlet_cell_start,
    output lim_transmit_load
  );
endinterface

// ### logic/cell_fifo.sv
/*
  small synchronous fifo with valid/ready on both sides.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ns
module cell_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_reg != rd_reg;
  assign o_out_data  = mem[rd_reg[AW-1:0]];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_reg <= '0;
      rd_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + 1'b1;
      if (pop)  rd_reg <= rd_reg + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) mem[wr_reg[AW-1:0]] <= i_in_data;
  end
endmodule

// ### logic/cell_port_device.sv
/*
  device end of the cell port: inlet acknowledge/reject, outlet cell sender
  with gfc insertion, atm/phy emulation and line-interface mode.
  assumes the far end follows the cell-available and enable handshakes.
*/
`timescale 1ns/1ns

module cell_port_device (
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  cell_port_if.device                       link,
  input  wire cell_port_pkg::port_mode_type i_mode,
  input  wire logic                         i_atm_layer,
  input  wire logic [1:0]                   i_port_clock_select,
  input  wire logic                         i_line_side_clock,
  input  wire logic [3:0]                   i_generic_flow,
  input  wire logic                         i_force_abr_congestion,
  input  wire logic                         i_cell_reject,
  input  wire logic                         i_lim_flush_request,
  input  wire logic                         i_tx_valid,
  output logic                              o_tx_ready,
  input  wire logic [7:0]                   i_tx_byte,
  input  wire logic                         i_tx_first,
  output logic                              o_outlet_transfer_clock,
  output logic                              o_outlet_enable_n,
  output logic                              o_outlet_cell_available,
  output logic                              o_lim_transmit_valid,
  output logic                              o_lim_receive_flush,
  output logic                              o_lim_flush_done,
  output logic                              o_lim_error_interrupt,
  output logic                              o_rx_valid,
  output logic [7:0]                        o_rx_byte,
  output logic                              o_rx_first
);
  typedef enum logic [1:0] {TX_IDLE, TX_SEND} tx_state_type;

  typedef struct packed {
    logic [1:0]   clk_sync;
    logic [1:0]   line_sync;
    logic [1:0]   clav_sync;
    logic [1:0]   enb_sync;
    logic [1:0]   load_sync;
    logic [1:0]   soc_sync;
    logic [1:0]   ienb_sync;
    logic [15:0]  data_sync;
    logic [1:0]   f2_sync;
    logic [1:0]   f4_sync;
    logic [1:0]   frc_sync;
    logic [7:0]   gfc_sync;
    logic         edge_prev;
    logic [2:0]   div_cnt;
    logic         clk_out;
    tx_state_type tx_state;
    logic [5:0]   tx_idx;
    logic         tx_enb_n;
    logic [7:0]   tx_data;
    logic         tx_soc;
    logic         tx_dval;
    logic [5:0]   rx_idx;
    logic         rx_busy;
    logic         ack;
    logic         rej;
    logic         rx_valid;
    logic [7:0]   rx_byte;
    logic         rx_first;
  } state_type;

  state_type st_reg;
  state_type st_next;
  logic      fifo_valid;
  logic      fifo_pop;
  logic [8:0] fifo_data;
  logic      is_line_if;
  logic      own_clock;
  logic      xfer_edge;
  logic      far_ready;
  logic      head_first;

  function automatic logic parity_odd(input logic [7:0] b);
    parity_odd = ~^b;
  endfunction

  // ------------------------------------------------------------
  // outlet staging buffer
  // ------------------------------------------------------------
  cell_fifo #(
    .WIDTH (cell_port_pkg::FIFO_WIDTH),
    .DEPTH (cell_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .i_in_data   ({i_tx_first, i_tx_byte}),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_data)
  );

  assign head_first = fifo_data[8];
  assign is_line_if = i_mode == cell_port_pkg::MODE_LINE_IF;
  assign own_clock  = i_atm_layer && !is_line_if && i_mode != cell_port_pkg::MODE_BACK_TO_BACK;

  // ------------------------------------------------------------
  // transfer edge selection
  // ------------------------------------------------------------
  always_comb begin
    if (i_port_clock_select == cell_port_pkg::LINE_CLK_SELECT) begin
      xfer_edge = st_reg.line_sync[1] && !st_reg.edge_prev;
    end else if (own_clock) begin
      xfer_edge = st_reg.div_cnt == cell_port_pkg::CLK_DIV_HALF && !st_reg.clk_out;
    end else if (is_line_if) begin
      xfer_edge = st_reg.clk_sync[1] && !st_reg.edge_prev && !st_reg.load_sync[1];
    end else begin
      xfer_edge = st_reg.clk_sync[1] && !st_reg.edge_prev;
    end
  end

  // the far end's enable only counts when it owns the enable
  always_comb begin
    if (own_clock) begin
      far_ready = st_reg.clav_sync[1] || st_reg.tx_state == TX_SEND;
    end else if (is_line_if) begin
      far_ready = 1'b1;
    end else begin
      far_ready = !st_reg.enb_sync[1];
    end
  end

  assign fifo_pop = xfer_edge && fifo_valid && far_ready
                    && (st_reg.tx_state == TX_SEND || head_first);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next            = st_reg;
    st_next.clk_sync   = {st_reg.clk_sync[0], link.outlet_transfer_clock};
    st_next.line_sync  = {st_reg.line_sync[0], i_line_side_clock};
    st_next.clav_sync  = {st_reg.clav_sync[0], link.outlet_cell_available};
    st_next.enb_sync   = {st_reg.enb_sync[0], link.outlet_enable_n};
    st_next.load_sync  = {st_reg.load_sync[0], link.lim_transmit_load};
    st_next.soc_sync   = {st_reg.soc_sync[0], link.inlet_cell_start};
    st_next.ienb_sync  = {st_reg.ienb_sync[0], link.inlet_enable_n};
    st_next.data_sync  = {st_reg.data_sync[7:0], link.inlet_byte_bus};
    st_next.f2_sync    = {st_reg.f2_sync[0], link.inlet_second_flag};
    st_next.f4_sync    = {st_reg.f4_sync[0], link.inlet_fourth_flag};
    st_next.frc_sync   = {st_reg.frc_sync[0], i_force_abr_congestion};
    st_next.gfc_sync   = {st_reg.gfc_sync[3:0], i_generic_flow};
    st_next.edge_prev  = (i_port_clock_select == cell_port_pkg::LINE_CLK_SELECT)
                         ? st_reg.line_sync[1] : st_reg.clk_sync[1];
    st_next.rx_valid   = 1'b0;
    st_next.ack        = 1'b0;
    st_next.rej        = 1'b0;
    // divider for the outlet clock we drive ourselves
    if (st_reg.div_cnt == cell_port_pkg::CLK_DIV_HALF) begin
      st_next.div_cnt = 3'h0;
      st_next.clk_out = !st_reg.clk_out;
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 3'h1;
    end

    if (xfer_edge) begin
      st_next.tx_enb_n = 1'b1;
      st_next.tx_dval  = 1'b0;
      st_next.tx_soc   = 1'b0;
      case (st_reg.tx_state)
        TX_IDLE: begin
          if (fifo_valid && !head_first) begin
            st_next.tx_state = TX_IDLE;
          end else if (fifo_valid && far_ready) begin
            st_next.tx_state = TX_SEND;
          end
        end
        TX_SEND: begin
          if (fifo_pop && st_reg.tx_idx == cell_port_pkg::LAST_BYTE_IDX) begin
            st_next.tx_state = TX_IDLE;
          end
        end
        default: st_next.tx_state = TX_IDLE;
      endcase
      if (fifo_pop) begin
        st_next.tx_data  = fifo_data[7:0];
        st_next.tx_idx   = (st_reg.tx_state == TX_IDLE) ? 6'h1 : st_reg.tx_idx + 6'h1;
        if (st_reg.tx_state == TX_IDLE) begin
          st_next.tx_data[cell_port_pkg::GFC_MSB:cell_port_pkg::GFC_LSB]
            = st_reg.gfc_sync[7:4];
        end
        st_next.tx_enb_n = 1'b0;
        st_next.tx_dval  = 1'b1;
        st_next.tx_soc   = is_line_if ? parity_odd(st_next.tx_data)
                                      : st_reg.tx_state == TX_IDLE;
        if (st_reg.tx_idx == cell_port_pkg::LAST_BYTE_IDX) begin
          st_next.tx_idx = 6'h0;
        end
      end
    end

    // inlet: sample a byte while the far end's enable is low
    if (!st_reg.ienb_sync[1] && !is_line_if) begin
      st_next.rx_valid = 1'b1;
      st_next.rx_byte  = st_reg.data_sync[15:8];
      st_next.rx_first = st_reg.soc_sync[1];
      if (st_reg.soc_sync[1]) begin
        st_next.rx_idx  = 6'h1;
        st_next.rx_busy = 1'b1;
      end else if (st_reg.rx_busy) begin
        st_next.rx_idx  = st_reg.rx_idx + 6'h1;
        if (st_reg.rx_idx == cell_port_pkg::PTI_BYTE_IDX && st_reg.frc_sync[1]
            && st_reg.data_sync[15:8] != cell_port_pkg::ACK_NONE) begin
          st_next.rx_byte[cell_port_pkg::PTI_CI_BIT] = 1'b1;
        end
        if (st_reg.rx_idx == cell_port_pkg::LAST_BYTE_IDX) begin
          st_next.rx_busy = 1'b0;
          st_next.ack     = !i_cell_reject;
          st_next.rej     = i_cell_reject;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg          <= '0;
      st_reg.clk_sync <= 2'h0;
      st_reg.enb_sync <= 2'h3;
      st_reg.ienb_sync <= 2'h3;
      st_reg.load_sync <= 2'h3;
      st_reg.tx_enb_n <= 1'b1;
      st_reg.tx_state <= TX_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign link.outlet_byte_bus   = st_reg.tx_data;
  assign link.outlet_cell_start = st_reg.tx_soc;
  assign link.inlet_ack_flag    = !is_line_if && st_reg.ack;
  assign link.inlet_reject_flag = !is_line_if && st_reg.rej;
  assign o_outlet_transfer_clock = own_clock && st_reg.clk_out;
  assign o_outlet_enable_n       = own_clock ? st_reg.tx_enb_n : 1'b1;
  assign o_outlet_cell_available = !i_atm_layer && !is_line_if
                                   && fifo_valid && head_first;
  assign o_lim_transmit_valid    = is_line_if && st_reg.tx_dval;
  assign o_lim_receive_flush     = is_line_if && i_lim_flush_request;
  assign o_lim_flush_done        = is_line_if && st_reg.f2_sync[1];
  assign o_lim_error_interrupt   = is_line_if && st_reg.f4_sync[1];
  assign o_rx_valid = st_reg.rx_valid;
  assign o_rx_byte  = st_reg.rx_byte;
  assign o_rx_first = st_reg.rx_first;
endmodule

// ### logic/cell_port_far_end.sv
/*
  far end of the cell port: phy-side receiver for device outlet cells and
  inlet cell sender.
  assumes the device's outlet clock, enable and cell-available stay off the
  link; this end drives those link pins, the bench watches the device's, and
  cell_port_props also watches the link's cell-available.
*/
`timescale 1ns/1ns
module cell_port_far_end (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  cell_port_if.far_end    link,
  input  wire logic       i_can_accept,
  input  wire logic       i_in_valid,
  input  wire logic [7:0] i_in_byte,
  input  wire logic       i_in_first,
  output logic            o_out_valid,
  output logic [7:0]      o_out_byte,
  output logic            o_out_first,
  output logic            o_ack,
  output logic            o_reject
);
  typedef struct packed {
    logic [1:0] ack_sync;
    logic [1:0] rej_sync;
    logic       out_valid;
    logic [7:0] out_byte;
    logic       out_first;
    logic [7:0] in_byte;
    logic       in_first;
    logic       in_enb_n;
    logic [2:0] clk_cnt;
  } state_type;

  state_type st_reg;
  state_type st_next;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next           = st_reg;
    st_next.ack_sync  = {st_reg.ack_sync[0], link.inlet_ack_flag};
    st_next.rej_sync  = {st_reg.rej_sync[0], link.inlet_reject_flag};
    st_next.out_valid = 1'b0;
    st_next.out_byte  = link.outlet_byte_bus;
    st_next.out_first = link.outlet_cell_start;
    st_next.in_enb_n  = !i_in_valid;
    st_next.in_byte   = i_in_byte;
    st_next.in_first  = i_in_valid && i_in_first;
    st_next.clk_cnt   = st_reg.clk_cnt + 3'h1;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_reg          <= '0;
      st_reg.in_enb_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // cell-available raised only when a whole cell fits
  assign link.outlet_cell_available = i_can_accept;
  // free-running, used when the device neither drives its own outlet clock nor selects the line clock
  assign link.outlet_transfer_clock = st_reg.clk_cnt[2];
  assign link.outlet_enable_n       = !i_can_accept;
  assign link.lim_transmit_load     = 1'b0;
  assign link.inlet_second_flag     = 1'b0;
  assign link.inlet_fourth_flag     = 1'b0;
  assign link.inlet_byte_bus        = st_reg.in_byte;
  assign link.inlet_cell_start      = st_reg.in_first;
  assign link.inlet_enable_n        = st_reg.in_enb_n;
  assign o_out_valid = st_reg.out_valid;
  assign o_out_byte  = st_reg.out_byte;
  assign o_out_first = st_reg.out_first;
  assign o_ack       = st_reg.ack_sync[1];
  assign o_reject    = st_reg.rej_sync[1];
endmodule

// ### sim/cell_port_props.sv
/*
  concurrent checks on the cell port link between the two design ends.
  assumes tb_top instantiates it beside the link; no bind is used.
*/
`timescale 1ns/1ns
module cell_port_props (
  input wire logic                         i_clk,
  input wire logic                         i_rstn,
  input wire cell_port_pkg::port_mode_type i_mode,
  input wire logic                         i_atm_layer,
  input wire logic [1:0]                   i_port_clock_select,
  input wire logic [3:0]                   i_generic_flow,
  input wire logic                         i_lim_flush_request,
  input wire logic                         o_outlet_transfer_clock,
  input wire logic                         o_outlet_enable_n,
  input wire logic                         o_lim_receive_flush,
  input wire logic                         inlet_ack_flag,
  input wire logic                         inlet_reject_flag,
  input wire logic                         inlet_enable_n,
  input wire logic                         outlet_cell_available,
  input wire logic [7:0]                   outlet_byte_bus,
  input wire logic                         outlet_cell_start
);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic line_mode;
  assign line_mode = (i_mode == cell_port_pkg::MODE_LINE_IF);
  sequence inlet_cell_end; $rose(inlet_enable_n) && !line_mode; endsequence
  sequence flag_answer; ##[0:8] (inlet_ack_flag || inlet_reject_flag); endsequence
  sequence start_held; outlet_cell_start [*8]; endsequence
  sequence start_gap; !outlet_cell_start [*8]; endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  ack_one_cycle_a: assert property (inlet_ack_flag |=> !inlet_ack_flag)
    else $error("ack flag stood longer than one cycle");
  flags_exclusive_a: assert property (!(inlet_ack_flag && inlet_reject_flag))
    else $error("ack and reject flags high together");
  cell_answered_a: assert property (inlet_cell_end |-> flag_answer)
    else $error("inlet cell got neither ack nor reject");
  start_shape_a: assert property ($rose(outlet_cell_start) && !line_mode |-> start_held ##1 start_gap)
    else $error("outlet start of cell not one transfer long");
  start_enabled_a: assert property (outlet_cell_start && !line_mode && i_atm_layer |-> !o_outlet_enable_n)
    else $error("start of cell without enable");
  wait_for_space_a: assert property ($fell(o_outlet_enable_n) |-> $past(outlet_cell_available))
    else $error("outlet cell began without far-end space");
  byte_on_edge_a: assert property (!o_outlet_enable_n && !$past(o_outlet_enable_n)
    && $changed(outlet_byte_bus) && i_port_clock_select != cell_port_pkg::LINE_CLK_SELECT
    |-> $rose(o_outlet_transfer_clock))
    else $error("outlet byte changed away from a transfer edge");
  gfc_inserted_a: assert property (outlet_cell_start && !o_outlet_enable_n && !line_mode
    |-> outlet_byte_bus[7:4] == $past(i_generic_flow, 12))
    else $error("gfc nibble not in first outlet byte");
  flush_follow_a: assert property (o_lim_receive_flush == (line_mode && i_lim_flush_request))
    else $error("receive flush output wrong for mode");
  phy_enable_idle_a: assert property (!i_atm_layer && !$past(i_atm_layer) |-> o_outlet_enable_n)
    else $error("outlet enable driven in phy emulation");
endmodule

// ### sim/tb_top.sv
/*
  self-checking bench: device end and far end joined by the link interface.
  assumes a 50 MHz clock; the line clock is made here at 160 ns.
*/
`timescale 1ns/1ns
module tb_top;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic                         i_clk = 1'b0;
  logic                         i_rstn = 1'b0;
  logic                         line_clk = 1'b0;
  logic                         line_run = 1'b0;
  cell_port_pkg::port_mode_type mode = cell_port_pkg::MODE_UTOPIA;
  logic                         atm = 1'b0, force_cng = 1'b0, reject = 1'b0;
  logic                         flush_req = 1'b0, tx_valid = 1'b0, tx_first = 1'b0;
  logic                         can_accept = 1'b0, in_valid = 1'b0, in_first = 1'b0;
  logic [1:0]                   clk_sel = 2'h0;
  logic [3:0]                   gfc = 4'h0;
  logic [7:0]                   tx_byte = 8'h00, in_byte = 8'h00, rx_byte;
  logic                         tx_ready, tclk, enable_n, clav, lim_valid, lim_flush;
  logic                         lim_done, lim_err, rx_valid, rx_first, tclk_prev = 1'b0;
  logic [31:0]                  lfsr = 32'hC522;
  logic [8:0]                   exp_out[$], exp_in[$];
  logic                         exp_rej[$];
  int                           fails = 0, num_checks = 0, tx_count = 0;

  always #10 i_clk = ~i_clk;
  initial begin
    #33;
    forever #80 line_clk = line_run ? ~line_clk : 1'b0;
  end

  cell_port_if link ();
  cell_port_device i_cell_port_device (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
    .i_mode(mode), .i_atm_layer(atm), .i_port_clock_select(clk_sel),
    .i_line_side_clock(line_clk), .i_generic_flow(gfc), .i_force_abr_congestion(force_cng),
    .i_cell_reject(reject), .i_lim_flush_request(flush_req), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .i_tx_byte(tx_byte), .i_tx_first(tx_first),
    .o_outlet_transfer_clock(tclk), .o_outlet_enable_n(enable_n),
    .o_outlet_cell_available(clav), .o_lim_transmit_valid(lim_valid),
    .o_lim_receive_flush(lim_flush), .o_lim_flush_done(lim_done),
    .o_lim_error_interrupt(lim_err), .o_rx_valid(rx_valid), .o_rx_byte(rx_byte),
    .o_rx_first(rx_first));
  cell_port_far_end i_cell_port_far_end (.i_clk(i_clk), .i_rstn(i_rstn), .link(link),
    .i_can_accept(can_accept), .i_in_valid(in_valid), .i_in_byte(in_byte),
    .i_in_first(in_first), .o_out_valid(), .o_out_byte(), .o_out_first(), .o_ack(),
    .o_reject());
  cell_port_props i_cell_port_props (.i_clk(i_clk), .i_rstn(i_rstn), .i_mode(mode),
    .i_atm_layer(atm), .i_port_clock_select(clk_sel), .i_generic_flow(gfc),
    .i_lim_flush_request(flush_req), .o_outlet_transfer_clock(tclk),
    .o_outlet_enable_n(enable_n), .o_lim_receive_flush(lim_flush),
    .inlet_ack_flag(link.inlet_ack_flag), .inlet_reject_flag(link.inlet_reject_flag),
    .inlet_enable_n(link.inlet_enable_n), .outlet_cell_available(link.outlet_cell_available),
    .outlet_byte_bus(link.outlet_byte_bus), .outlet_cell_start(link.outlet_cell_start));

  // ----------------------------------------
  // tasks and monitors
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction

  task automatic check(input string what, input logic [8:0] expv, input logic [8:0] seen);
    num_checks++;
    if (expv !== seen) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // gfc rides through two sync flops, so let it settle before a cell
  task automatic new_gfc();
    gfc = 4'(rnd() >> 4);
    repeat (16) @(negedge i_clk);
  endtask

  task automatic push_byte(input logic [7:0] b, input logic first);
    @(negedge i_clk);
    tx_valid = 1'b1;
    tx_byte = b;
    tx_first = first;
    while (tx_ready !== 1'b1) @(negedge i_clk);
    exp_out.push_back({first, first ? {gfc, b[3:0]} : b});
    @(posedge i_clk);
    tx_count++;
  endtask

  task automatic send_out(input int from);
    for (int i = from; i < cell_port_pkg::CELL_BYTES; i++) push_byte(rnd(), i == 0);
    @(negedge i_clk);
    tx_valid = 1'b0;
  endtask

  task automatic drain();
    int n = 0;
    while (exp_out.size() > 0 && n < 3000) begin
      @(negedge i_clk);
      n++;
    end
    repeat (40) @(negedge i_clk);
    check("outlet left", 9'h000, 9'(exp_out.size()));
    check("enable idle", 9'h001, {8'h00, enable_n});
  endtask

  task automatic send_in(input logic r, input logic cng);
    logic [7:0] b;
    @(negedge i_clk);
    reject = r;
    force_cng = cng;
    repeat (4) @(negedge i_clk);
    exp_rej.push_back(r);
    for (int i = 0; i < cell_port_pkg::CELL_BYTES; i++) begin
      b = rnd();
      in_valid = 1'b1;
      in_byte = b;
      in_first = (i == 0);
      if (cng && i == int'(cell_port_pkg::PTI_BYTE_IDX) && b != 8'h00)
        b[cell_port_pkg::PTI_CI_BIT] = 1'b1;
      exp_in.push_back({in_first, b});
      @(negedge i_clk);
    end
    in_valid = 1'b0;
    repeat (20) @(negedge i_clk);
  endtask

  // outlet bytes taken at the rising edge of whichever clock times transfers
  always @(negedge i_clk) begin
    logic t, r;
    t = (clk_sel == cell_port_pkg::LINE_CLK_SELECT) ? line_clk : tclk;
    if (t && !tclk_prev && enable_n === 1'b0)
      check("outlet byte", exp_out.size() > 0 ? exp_out.pop_front() : 'x,
            {link.outlet_cell_start, link.outlet_byte_bus});
    tclk_prev <= t;
    if (rx_valid === 1'b1)
      check("inlet byte", exp_in.size() > 0 ? exp_in.pop_front() : 'x,
            {rx_first, rx_byte});
    if (link.inlet_ack_flag === 1'b1 || link.inlet_reject_flag === 1'b1) begin
      r = exp_rej.size() > 0 ? exp_rej.pop_front() : 1'bx;
      check("inlet flags", {7'h00, !r, r},
            {7'h00, link.inlet_ack_flag, link.inlet_reject_flag});
    end
  end

  initial begin
    #1000000;
    fails++;
    end_of_test();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge i_clk);
    i_rstn = 1'b1;
    new_gfc();
    @(posedge i_clk);
    check("cell available", 9'h000, {8'h00, clav});
    push_byte(rnd(), 1'b1);
    @(negedge i_clk);
    tx_valid = 1'b0;
    @(posedge i_clk);
    check("cell available", 9'h001, {8'h00, clav});
    @(negedge i_clk);
    mode = cell_port_pkg::MODE_BACK_TO_BACK;
    @(posedge i_clk);
    check("cell available", 9'h001, {8'h00, clav});
    // atm emulation, far end full: fifo must fill and refuse
    @(negedge i_clk);
    mode = cell_port_pkg::MODE_UTOPIA;
    atm = 1'b1;
    tx_count = 1;
    fork
      send_out(1);
    join_none
    repeat (60) @(negedge i_clk);
    check("fifo fill", 9'(cell_port_pkg::FIFO_DEPTH), 9'(tx_count));
    check("fifo refuses", 9'h000, {8'h00, tx_ready});
    check("no start", 9'h001, {8'h00, enable_n});
    can_accept = 1'b1;
    wait fork;
    drain();
    // two cells in a row, far end stalls in the middle
    new_gfc();
    fork
      begin
        send_out(0);
        send_out(0);
      end
      begin
        repeat (200) @(negedge i_clk);
        can_accept = 1'b0;
        repeat (400) @(negedge i_clk);
        can_accept = 1'b1;
      end
    join
    drain();
    // transfers timed by the line clock
    clk_sel = cell_port_pkg::LINE_CLK_SELECT;
    line_run = 1'b1;
    new_gfc();
    send_out(0);
    drain();
    line_run = 1'b0;
    clk_sel = 2'h0;
    // inlet cells: ack, reject, forced congestion
    send_in(1'b0, 1'b0);
    send_in(1'b1, 1'b1);
    send_in(1'b0, 1'b1);
    check("inlet left", 9'h000, 9'(exp_in.size() + exp_rej.size()));
    // line-interface mode flush path, then back to utopia
    mode = cell_port_pkg::MODE_LINE_IF;
    repeat (16) begin
      @(negedge i_clk);
      flush_req = 1'(rnd() >> 7);
      @(posedge i_clk);
      check("receive flush", {8'h00, flush_req}, {8'h00, lim_flush});
    end
    @(negedge i_clk);
    mode = cell_port_pkg::MODE_UTOPIA;
    flush_req = 1'b1;
    @(posedge i_clk);
    check("flush off", 9'h000, {8'h00, lim_flush});
    check("flush done off", 9'h000, {8'h00, lim_done});
    check("error off", 9'h000, {8'h00, lim_err});
    check("valid off", 9'h000, {8'h00, lim_valid});
    end_of_test();
  end
endmodule
